// file: dv/lin_node_model.sv
`timescale 1ns/1ps
// far-side bus node: drives the receive line, times what the device sends
module lin_node_model #(
  parameter int TBIT = 16
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd,
  output int        low_len,
  output int        nbrk
);
  int run = 0;

  // ****************************************
  // low runs seen on the device output
  // ****************************************
  // counted per clock so a stretched break shows up as a wrong length
  always @(posedge clk) begin
    if (txd === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run > 0) begin
        low_len <= run;
        nbrk    <= nbrk + 1;
      end
      run <= 0;
    end
  end

  // line idles high, as the bus pull-up would leave it
  initial begin
    rxd     = 1'b1;
    low_len = 0;
    nbrk    = 0;
  end

  // ****************************************
  // line drivers
  // ****************************************
  // one bit is TBIT clocks, sixteen sample ticks of the receiver
  task automatic send_low(input int bits);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (bits * TBIT) @(posedge clk);
    rxd <= 1'b1;
  endtask

  // start bit, data lsb first, stop bit
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] frame;
    frame = {1'b1, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (TBIT) @(posedge clk);
    end
  endtask
endmodule

// file: dv/lin_serial_break_header_tb.sv
`timescale 1ns/1ps
module lin_serial_break_header_tb;
  localparam int          TBIT = 16 * int'(lin_break_pkg::BAUD_RESET);
  localparam logic [31:0] TXEN = 32'h1 << lin_break_pkg::BIT_TXEN;
  localparam logic [31:0] SBRK = 32'h1 << lin_break_pkg::BIT_SENDBRK;
  localparam logic [31:0] RXEN = 32'h1 << lin_break_pkg::BIT_RXEN;
  localparam logic [31:0] MUTE = 32'h1 << lin_break_pkg::BIT_MUTE;
  logic        clk = 1'b0;
  logic        arst_n, ce, psel, penable, pwrite;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, r;
  logic        pready, rxd, txd, irq;
  int          errors = 0;
  int          n_tests = 0;
  int          seed = 32'h4CF89065;
  int          low_len, nbrk, n0;

  always #2.5 clk = ~clk;

  lin_serial_break_header lin_serial_break_header_inst (
    .REF_CLK(clk), .ARST_N(arst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(), .RXD(rxd), .TXD(txd), .IRQ(irq));

  lin_node_model #(.TBIT(TBIT)) lin_node_model_inst (
    .clk(clk), .txd(txd), .rxd(rxd), .low_len(low_len), .nbrk(nbrk));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // break length in clocks from mode bits
  function automatic int brk_cycles(input logic wl, input logic lin);
    return (lin ? 13 : (wl ? 11 : 10)) * TBIT;
  endfunction

  // ****************************************
  // apb master
  // ****************************************
  // request held until pready is seen high; the watchdog bounds the wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // tx off then on queues the idle, then one set-clear break
  task automatic brk_case(input logic wl, input logic lin);
    wr(lin_break_pkg::ADDR_CTRL2, 32'h0);
    wr(lin_break_pkg::ADDR_CTRL1, 32'(wl) << lin_break_pkg::BIT_WORDLEN);
    wr(lin_break_pkg::ADDR_CTRL3, 32'(lin) << lin_break_pkg::BIT_LINEN);
    n0 = nbrk;
    wr(lin_break_pkg::ADDR_CTRL2, TXEN);
    wr(lin_break_pkg::ADDR_CTRL2, TXEN | SBRK);
    wr(lin_break_pkg::ADDR_CTRL2, TXEN);
    repeat (36 * TBIT) @(posedge clk);
    chk(nbrk - n0, 1);
    chk(low_len, brk_cycles(wl, lin));
    chk(txd, 1'b1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk(txd, 1'b1);
    chk(irq, 1'b0);
    rd(lin_break_pkg::ADDR_BAUD);
    chk(r, 32'(lin_break_pkg::BAUD_RESET));
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C);
    chk(r, 32'h0);
    brk_case(1'b0, 1'b0);
    brk_case(1'b1, 1'b0);
    brk_case(1'b0, 1'b1);
    // send-break held: breaks keep coming
    wr(lin_break_pkg::ADDR_CTRL3, 32'h0);
    n0 = nbrk;
    wr(lin_break_pkg::ADDR_CTRL2, TXEN | SBRK);
    repeat (40 * TBIT) @(posedge clk);
    wr(lin_break_pkg::ADDR_CTRL2, TXEN);
    repeat (20 * TBIT) @(posedge clk);
    chk(32'(nbrk - n0 >= 2), 1);
    // slave header with no sync or id: time-out
    wr(lin_break_pkg::ADDR_CTRL3, 32'h60);
    wr(lin_break_pkg::ADDR_CTRL2, RXEN | MUTE);
    lin_node_model_inst.send_low(13);
    repeat (70 * TBIT) @(posedge clk);
    rd(lin_break_pkg::ADDR_STATUS);
    chk(r[lin_break_pkg::BIT_HDRERR], 1'b1);
    chk(r[lin_break_pkg::BIT_HDRDET], 1'b0);
    chk(r[lin_break_pkg::BIT_RXFULL], 1'b0);
    chk(irq, 1'b1);
    rd(lin_break_pkg::ADDR_DATA);
    rd(lin_break_pkg::ADDR_STATUS);
    chk(r[lin_break_pkg::BIT_HDRERR], 1'b0);
    rd(lin_break_pkg::ADDR_HLEN);
    chk(r, 32'h0);
    rd(lin_break_pkg::ADDR_CTRL2);
    chk(r[lin_break_pkg::BIT_MUTE], 1'b1);
    // unmuted plain receiver: every byte flags, corners then random
    wr(lin_break_pkg::ADDR_CTRL3, 32'h0);
    wr(lin_break_pkg::ADDR_CTRL2, RXEN);
    for (int i = 0; i < 5; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      lin_node_model_inst.send_byte(b);
      repeat (2 * TBIT) @(posedge clk);
      rd(lin_break_pkg::ADDR_STATUS);
      chk(r[lin_break_pkg::BIT_RXFULL], 1'b1);
      chk(irq, 1'b1);
      rd(lin_break_pkg::ADDR_DATA);
      chk(r[7:0], b);
      rd(lin_break_pkg::ADDR_STATUS);
      chk(r[lin_break_pkg::BIT_RXFULL], 1'b0);
    end
    wr(lin_break_pkg::ADDR_CTRL2, RXEN | MUTE);
    rd(lin_break_pkg::ADDR_CTRL2);
    chk(r[lin_break_pkg::BIT_MUTE], 1'b1);
    test_done();
  end

  // hang guard, well beyond the few thousand clocks the run needs
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    test_done();
  end
endmodule

// file: src/lin_break_pkg.sv
// How it works
// (RULE1) setting then clearing the send-break bit sends exactly one break character
// (RULE2) serial mode break lasts 10 bit times, or 11 with long word length
// (RULE3) breaks repeat back to back while the send-break bit stays set
// (RULE4) LIN master mode when LIN enable set and long word length clear
// (RULE5) a LIN master break lasts 13 bit times
// (RULE6) transmit enable off then on queues an idle before any following break
// (RULE7) LIN slave header longer than 57 bit times sets header error, interrupt
// (RULE8) after header time-out the receiver stays muted for the next header
// (RULE9) receiver samples the line sixteen times per bit
// (RULE10) header time-out loads header length with zero, header detect stays clear
// (RULE11) status read then data read clears header error and receive full
// (RULE12) receiver mute bit shows mute; software may set it to mute again
// (RULE13) unmuted receiver raises a receive interrupt for every data byte
// (RULE14) break holds the line low its whole length then one high stop bit
package lin_break_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DATA   = 8'h04;
  localparam logic [7:0] ADDR_CTRL1  = 8'h08;
  localparam logic [7:0] ADDR_CTRL2  = 8'h0C;
  localparam logic [7:0] ADDR_CTRL3  = 8'h10;
  localparam logic [7:0] ADDR_HLEN   = 8'h14;
  localparam logic [7:0] ADDR_BAUD   = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_WORDLEN   = 4;  // control_reg_one
  localparam int BIT_SENDBRK   = 0;  // control_reg_two
  localparam int BIT_MUTE      = 1;
  localparam int BIT_TXEN      = 3;
  localparam int BIT_RXEN      = 2;
  localparam int BIT_LINEN     = 6;  // control_reg_three
  localparam int BIT_LINSLV    = 5;
  localparam int BIT_RXFULL    = 5;  // serial_status_reg
  localparam int BIT_HDRERR    = 2;
  localparam int BIT_HDRDET    = 1;
  localparam int BIT_TXIDLE    = 6;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [15:0] BAUD_RESET   = 16'h0001;  // ticks of 1/16 bit
  localparam logic [5:0]  BRK_BITS_SER = 6'h0A;
  localparam logic [5:0]  BRK_BITS_LNG = 6'h0B;
  localparam logic [5:0]  BRK_BITS_LIN = 6'h0D;
  localparam logic [5:0]  IDLE_BITS    = 6'h0A;
  localparam logic [5:0]  HDR_MAX_BITS = 6'h39;  // 57
  localparam logic [3:0]  OSR_LAST     = 4'hF;   // 16 samples per bit

  typedef struct packed {
    logic       word_long;
    logic       lin_en;
    logic       lin_slave;
    logic       tx_en;
    logic       rx_en;
  } cfg_t;

endpackage

// file: src/lin_rx_sampler.sv
`timescale 1ns/1ps
// 16x oversampling receiver: frames bytes, flags an all-zero frame with low stop bit as a break
module lin_rx_sampler (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       rxd,
  output logic            byte_stb,
  output logic [7:0]      byte_q,
  output logic            brk_stb
);
  logic [3:0] smp_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic       busy_q;

  // ****************************************
  // sampling at bit/16
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smp_q    <= 4'h0;
      bit_q    <= 4'h0;
      sh_q     <= 9'h000;
      busy_q   <= 1'b0;
      byte_stb <= 1'b0;
      brk_stb  <= 1'b0;
      byte_q   <= 8'h00;
    end else if (ce) begin
      byte_stb <= 1'b0;
      brk_stb  <= 1'b0;
      if (tick) begin // RULE9
        if (!busy_q) begin
          if (!rxd) begin
            busy_q <= 1'b1;
            smp_q  <= 4'h0;
            bit_q  <= 4'h0;
          end
        end else begin
          smp_q <= smp_q + 4'h1;
          if (smp_q == 4'h7) begin // mid-bit sample
            sh_q  <= {rxd, sh_q[8:1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h9) begin
              busy_q <= 1'b0;
              // all-zero with low stop bit means a break
              if (!rxd && sh_q[8:1] == 8'h00) begin
                brk_stb <= 1'b1;
              end else begin
                byte_stb <= rxd;
                byte_q   <= sh_q[8:1];
              end
            end
          end
        end
      end
    end
  end
endmodule

// file: src/lin_serial_break_header.sv
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lin_serial_break_header (
  input  wire logic        REF_CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RXD,
  output logic             TXD,
  output logic             IRQ
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  ctrl1_q, ctrl2_q, ctrl3_q, hlen_q, data_q;
  logic [15:0] baud_q;
  logic        rxfull_q, hdrerr_q, hdrdet_q, stat_rd_q;
  logic [1:0]  rx_sync_q;
  logic [15:0] div_q;
  logic        tick;
  logic        wr, rd;
  lin_break_pkg::cfg_t cfg;

  assign cfg.word_long = ctrl1_q[lin_break_pkg::BIT_WORDLEN];
  assign cfg.lin_en    = ctrl3_q[lin_break_pkg::BIT_LINEN];
  assign cfg.lin_slave = ctrl3_q[lin_break_pkg::BIT_LINSLV];
  assign cfg.tx_en     = ctrl2_q[lin_break_pkg::BIT_TXEN];
  assign cfg.rx_en     = ctrl2_q[lin_break_pkg::BIT_RXEN];

  assign wr      = PSEL && PENABLE && PWRITE && CE;
  assign rd      = PSEL && PENABLE && !PWRITE && CE;
  assign PREADY  = 1'b1;  // zero wait states
  assign PSLVERR = 1'b0;

  // ****************************************
  // two-flop synchroniser on the line
  // ****************************************
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) rx_sync_q <= 2'b11;
    else if (CE) rx_sync_q <= {rx_sync_q[0], RXD};
  end

  // oversample tick: baud_q is the period of one sixteenth bit
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) div_q <= 16'h0000;
    else if (CE) div_q <= (div_q + 16'h0001 >= baud_q) ? 16'h0000 : div_q + 16'h0001;
  end
  assign tick = (div_q + 16'h0001 >= baud_q);

  // ****************************************
  // transmit: idle and break sequencer
  // ****************************************
  typedef enum logic [2:0] {
    TX_OFF  = 3'b001,
    TX_IDLE = 3'b010,
    TX_BRK  = 3'b100
  } tx_st_t;
  tx_st_t      tx_q;
  logic [3:0]  tsmp_q;
  logic [5:0]  tbits_q;
  logic [5:0]  brk_len;
  logic        brk_pend_q, txen_dly_q, lin_master;
  logic        sbk_now;

  assign lin_master = cfg.lin_en && !cfg.word_long; // RULE4
  assign brk_len = lin_master ? lin_break_pkg::BRK_BITS_LIN :          // RULE5
                   cfg.word_long ? lin_break_pkg::BRK_BITS_LNG :
                   lin_break_pkg::BRK_BITS_SER;                        // RULE2
  assign sbk_now = ctrl2_q[lin_break_pkg::BIT_SENDBRK];

  // a set-then-clear of send-break latches one pending break
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) brk_pend_q <= 1'b0;
    else if (CE) begin
      if (sbk_now) brk_pend_q <= 1'b1; // RULE1
      else if (tx_q == TX_BRK && tbits_q == 6'h00 && tsmp_q == 4'h0) brk_pend_q <= 1'b0;
    end
  end

  // bit-exact lengths: the sequencer restarts the bit grid on entry,
  // so a break never stretches to a doubled length
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_q       <= TX_OFF;
      tsmp_q     <= 4'h0;
      tbits_q    <= 6'h00;
      txen_dly_q <= 1'b0;
      TXD        <= 1'b1;
    end else if (CE) begin
      txen_dly_q <= cfg.tx_en;
      case (tx_q)
        TX_OFF: begin
          TXD <= 1'b1;
          if (cfg.tx_en && !txen_dly_q) begin // RULE6
            tx_q    <= TX_IDLE;
            tbits_q <= lin_break_pkg::IDLE_BITS;
            tsmp_q  <= lin_break_pkg::OSR_LAST;
          end else if (cfg.tx_en && brk_pend_q) begin
            tx_q    <= TX_BRK;
            tbits_q <= brk_len;
            tsmp_q  <= lin_break_pkg::OSR_LAST;
          end
        end
        TX_IDLE, TX_BRK: begin
          // break low for its count, then one high stop bit
          TXD <= (tx_q == TX_BRK && tbits_q != 6'h00) ? 1'b0 : 1'b1; // RULE14
          if (!cfg.tx_en) tx_q <= TX_OFF;
          else if (tick) begin
            if (tsmp_q != 4'h0) tsmp_q <= tsmp_q - 4'h1;
            else begin
              tsmp_q <= lin_break_pkg::OSR_LAST;
              if (tbits_q != 6'h00) tbits_q <= tbits_q - 6'h01;
              else if (sbk_now) begin
                tx_q    <= TX_BRK; // RULE3
                tbits_q <= brk_len;
              end else tx_q <= TX_OFF;
            end
          end
        end
        default: tx_q <= TX_OFF;
      endcase
    end
  end

  // ****************************************
  // receive and LIN slave header watch
  // ****************************************
  logic       byte_stb, brk_stb;
  logic [7:0] rx_byte;
  logic [5:0] hbits_q;
  logic [3:0] hsmp_q;
  logic [1:0] hfld_q;
  logic       hdr_q, hdr_to, clr_seq;

  lin_rx_sampler u_rx (
    .clk      (REF_CLK),
    .arst_n   (ARST_N),
    .ce       (CE),
    .tick     (tick),
    .rxd      (rx_sync_q[1]),
    .byte_stb (byte_stb),
    .byte_q   (rx_byte),
    .brk_stb  (brk_stb)
  );

  assign hdr_to  = hdr_q && tick && hsmp_q == 4'h0 &&
                   hbits_q == lin_break_pkg::HDR_MAX_BITS;
  // status read armed, then data read clears
  assign clr_seq = rd && PADDR == lin_break_pkg::ADDR_DATA && stat_rd_q;

  // header timer counts whole bits from break detection
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hdr_q   <= 1'b0;
      hbits_q <= 6'h00;
      hsmp_q  <= 4'h0;
      hfld_q  <= 2'b00;
    end else if (CE) begin
      if (brk_stb && cfg.lin_en && cfg.lin_slave) begin
        hdr_q   <= 1'b1;
        hbits_q <= lin_break_pkg::BRK_BITS_SER;
        hsmp_q  <= lin_break_pkg::OSR_LAST;
        hfld_q  <= 2'b00;
      end else if (hdr_q) begin
        if (hdr_to) hdr_q <= 1'b0; // RULE7
        else if (byte_stb && hfld_q == 2'b01) hdr_q <= 1'b0;
        else begin
          if (byte_stb) hfld_q <= hfld_q + 2'b01;
          if (tick) begin
            hsmp_q <= hsmp_q - 4'h1;
            if (hsmp_q == 4'h0) hbits_q <= hbits_q + 6'h01;
          end
        end
      end
    end
  end

  // flags: hardware set wins over the read-sequence clear
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rxfull_q  <= 1'b0;
      hdrerr_q  <= 1'b0;
      hdrdet_q  <= 1'b0;
      hlen_q    <= 8'h00;
      data_q    <= 8'h00;
      stat_rd_q <= 1'b0;
    end else if (CE) begin
      if (rd) stat_rd_q <= (PADDR == lin_break_pkg::ADDR_STATUS);
      if (hdr_to) begin
        hdrerr_q <= 1'b1;  // RULE7
        hlen_q   <= 8'h00; // RULE10
        hdrdet_q <= 1'b0;  // RULE10
      end else if (clr_seq) hdrerr_q <= 1'b0; // RULE11
      if (hdr_q && byte_stb && hfld_q == 2'b01 && !hdr_to) begin
        hdrdet_q <= 1'b1;
        hlen_q   <= {2'b00, hbits_q};
      end else if (clr_seq) hdrdet_q <= 1'b0;
      // muted or disabled receiver keeps quiet; enabled and unmuted reports each byte
      if (byte_stb && cfg.rx_en && !ctrl2_q[lin_break_pkg::BIT_MUTE]) begin
        rxfull_q <= 1'b1; // RULE13
        data_q   <= rx_byte;
      end else if (clr_seq) rxfull_q <= 1'b0; // RULE11
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl1_q <= 8'h00;
      ctrl2_q <= 8'h00;
      ctrl3_q <= 8'h00;
      baud_q  <= lin_break_pkg::BAUD_RESET;
    end else if (CE) begin
      if (wr && PADDR == lin_break_pkg::ADDR_CTRL1) ctrl1_q <= PWDATA[7:0];
      if (wr && PADDR == lin_break_pkg::ADDR_CTRL3) ctrl3_q <= PWDATA[7:0];
      if (wr && PADDR == lin_break_pkg::ADDR_BAUD) baud_q <= PWDATA[15:0];
      if (wr && PADDR == lin_break_pkg::ADDR_CTRL2) ctrl2_q <= PWDATA[7:0]; // RULE12
      // a time-out beats a clearing write in the same cycle
      if (hdr_to) ctrl2_q[lin_break_pkg::BIT_MUTE] <= 1'b1; // RULE8
    end
  end

  // read mux, unmapped reads as zero
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (PADDR)
      lin_break_pkg::ADDR_STATUS: begin
        rdata_d[lin_break_pkg::BIT_RXFULL] = rxfull_q;
        rdata_d[lin_break_pkg::BIT_HDRERR] = hdrerr_q;
        rdata_d[lin_break_pkg::BIT_HDRDET] = hdrdet_q;
        rdata_d[lin_break_pkg::BIT_TXIDLE] = (tx_q == TX_OFF);
      end
      lin_break_pkg::ADDR_DATA:  rdata_d[7:0] = data_q;
      lin_break_pkg::ADDR_CTRL1: rdata_d[7:0] = ctrl1_q;
      lin_break_pkg::ADDR_CTRL2: rdata_d[7:0] = ctrl2_q;
      lin_break_pkg::ADDR_CTRL3: rdata_d[7:0] = ctrl3_q;
      lin_break_pkg::ADDR_HLEN:  rdata_d[7:0] = hlen_q;
      lin_break_pkg::ADDR_BAUD:  rdata_d[15:0] = baud_q;
      default:                   rdata_d = 32'h0000_0000;
    endcase
  end

  // read data caught at the setup edge, so it stands through the access
  // phase even if a flag moves under it; the clear still lands at access
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) PRDATA <= 32'h0000_0000;
    else if (CE && PSEL && !PENABLE) PRDATA <= rdata_d;
  end

  assign IRQ = rxfull_q || hdrerr_q || hdrdet_q; // RULE7

  // ****************************************
  // checks
  // ****************************************
  chk_break_line_low: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE14
    (tx_q == TX_BRK && tbits_q != 6'h00 && CE) |=> !TXD)
    else $error("break not driving line low");
  chk_timeout_flags: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE10
    (hdr_to && CE) |=> (hdrerr_q && hlen_q == 8'h00 && !hdrdet_q))
    else $error("timeout flags wrong");
  chk_timeout_mute: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE8
    (hdr_to && CE && !wr) |=> ctrl2_q[lin_break_pkg::BIT_MUTE])
    else $error("receiver not muted after timeout");
  chk_lin_len: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE5
    (tx_q == TX_OFF && cfg.tx_en && txen_dly_q && brk_pend_q && lin_master && CE)
    |=> (tx_q == TX_BRK && tbits_q == 6'h0D))
    else $error("lin break length wrong");
  chk_ser_len: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE2
    (tx_q == TX_OFF && cfg.tx_en && txen_dly_q && brk_pend_q && !lin_master && CE)
    |=> (tx_q == TX_BRK && tbits_q == (cfg.word_long ? 6'h0B : 6'h0A)))
    else $error("serial break length wrong");
  chk_break_repeat: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE3
    (tx_q != TX_OFF && cfg.tx_en && tick && tsmp_q == 4'h0 && tbits_q == 6'h00 &&
     sbk_now && CE) |=> tx_q == TX_BRK)
    else $error("held send-break did not repeat");
  chk_stop_high: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE14
    (tx_q == TX_BRK && tbits_q == 6'h00 && CE) |=> TXD)
    else $error("stop bit after break not high");
  chk_mute_quiet: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE8
    (byte_stb && ctrl2_q[lin_break_pkg::BIT_MUTE] && !rxfull_q && CE) |=> !rxfull_q)
    else $error("muted receiver flagged a byte");
  chk_clear_seq: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE11
    (clr_seq && !byte_stb && !hdr_to && CE) |=> (!rxfull_q && !hdrerr_q))
    else $error("read sequence left flags set");
  chk_irq_err: assert property (@(posedge REF_CLK) disable iff (!ARST_N) // RULE7
    hdrerr_q |-> IRQ)
    else $error("header error without interrupt");
  cov_break: cover property (@(posedge REF_CLK) tx_q == TX_BRK);
  cov_timeout: cover property (@(posedge REF_CLK) hdr_to);
  cov_clear: cover property (@(posedge REF_CLK) clr_seq);
  cov_lin_break: cover property (@(posedge REF_CLK) tx_q == TX_BRK && lin_master);
  cov_detect: cover property (@(posedge REF_CLK) hdrdet_q);
endmodule
